// ==== logic/eprc_pkg.sv ====
// shared constants for the serial memory command controller
package eprc_pkg;

   // ------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------
   localparam int           ADDR_W           = 12;
   localparam logic [11:0]  OFS_CMD          = 12'h0B0;
   localparam logic [11:0]  OFS_DATA         = 12'h0B4;
   localparam logic [11:0]  OFS_IRQ_STAT     = 12'h0B8;
   localparam logic [11:0]  OFS_IRQ_MASK     = 12'h0BC;

   // ------------------------------------------------------------------
   // command register fields
   // ------------------------------------------------------------------
   localparam int           CMD_BUSY_BIT     = 31;
   localparam int           CMD_OP_LSB       = 28;
   localparam int           CMD_TMO_BIT      = 9;
   localparam int           CMD_LOADED_BIT   = 8;
   localparam logic [7:0]   CMD_ADDR_RST     = 8'h00;
   localparam logic [7:0]   DATA_RST         = 8'h00;

   // interrupt status / mask bits
   localparam int           IRQ_DONE_BIT     = 0;
   localparam int           IRQ_TMO_BIT      = 1;
   localparam logic [1:0]   IRQ_MASK_RST     = 2'h0;

   // ------------------------------------------------------------------
   // operations selected by software in bits 30:28
   // ------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      EPRC_OP_READ   = 3'h0,
      EPRC_OP_DISWR  = 3'h1,
      EPRC_OP_ENWR   = 3'h2,
      EPRC_OP_WRITE  = 3'h3,
      EPRC_OP_WRALL  = 3'h4,
      EPRC_OP_ERASE  = 3'h5,
      EPRC_OP_ERALL  = 3'h6,
      EPRC_OP_RELOAD = 3'h7
   } eprc_op_t;

   // serial frame: start bit, two opcode bits, eight location bits
   localparam int           HDR_BITS         = 11;
   localparam int           BYTE_BITS        = 8;
   localparam logic [1:0]   WIRE_READ        = 2'h2;
   localparam logic [1:0]   WIRE_WRITE       = 2'h1;
   localparam logic [1:0]   WIRE_ERASE       = 2'h3;
   localparam logic [1:0]   WIRE_EXT         = 2'h0;
   localparam logic [7:0]   EXT_DISWR        = 8'h00;
   localparam logic [7:0]   EXT_WRALL        = 8'h40;
   localparam logic [7:0]   EXT_ERALL        = 8'h80;
   localparam logic [7:0]   EXT_ENWR         = 8'hC0;

   // station address reload: signature byte then six address bytes
   localparam logic [7:0]   RELOAD_SIG       = 8'hA5;
   localparam logic [2:0]   RELOAD_LAST      = 3'h6;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int           CLK_NS           = 8;
   localparam int           TMO_MS           = 30;
   localparam int           TMO_CYC_DEF      = TMO_MS * 1000000 / CLK_NS;
   localparam int           TMO_W            = 22;
   localparam int           SCLK_HALF_NS     = 250;
   localparam int           SCLK_HALF_CYC    = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int           SCLK_W           = 8;

endpackage

// ==== logic/eprc_tick.sv ====
// free counter that pulses once every limit cycles while run is high
`timescale 1ns/100ps
module eprc_tick
#(
   parameter int W = 8
)
(
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         run,
   input  wire logic [W-1:0] limit,
   output      logic         hit
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;

   assign hit     = run && (cnt_ff == limit - W'(1));
   assign nxt_cnt = (!run || hit) ? '0 : cnt_ff + W'(1);

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         cnt_ff <= '0;
      else
         cnt_ff <= nxt_cnt;
   end

endmodule

// ==== logic/eprc_ctrl.sv ====
// serial memory command controller with apb registers
`timescale 1ns/100ps
module eprc_ctrl
   import eprc_pkg::*;
#(
   parameter int TMO_CYCLES = eprc_pkg::TMO_CYC_DEF,
   parameter int SCLK_HALF  = eprc_pkg::SCLK_HALF_CYC
)
(
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   input  wire logic [eprc_pkg::ADDR_W-1:0] paddr,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [31:0]               pwdata,
   output      logic [31:0]               prdata,
   output      logic                      pready,
   output      logic                      pslverr,
   output      logic                      irq,
   output      logic                      mem_cs,
   output      logic                      mem_clk,
   output      logic                      mem_dio_o,
   output      logic                      mem_dio_oe,
   input  wire logic                      mem_dio_i,
   output      logic [47:0]               station_addr
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP, ST_POLL} eprc_state_t;

   eprc_state_t   st_ff;
   eprc_op_t      op_ff;
   logic [7:0]    addr_ff;
   logic [7:0]    data_ff;
   logic          busy_ff;
   logic          tmo_ff;
   logic          loaded_ff;
   logic          boot_ff;
   logic          rl_ff;
   logic [2:0]    rl_idx_ff;
   logic [47:0]   sta_ff;
   logic [18:0]   sh_out_ff;
   logic [7:0]    sh_in_ff;
   logic [4:0]    bit_ff;
   logic [4:0]    nbits_ff;
   logic [4:0]    nsend_ff;
   logic          sclk_ff;
   logic          cs_ff;
   logic          oe_ff;
   logic [1:0]    irq_st_ff;
   logic [1:0]    irq_mask_ff;
   logic [31:0]   prdata_ff;
   logic          din_meta_ff;
   logic          din_ff;
   logic          rl_go_ff;
   logic [1:0]    poll_age_ff;

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   wire           sel_cmd   = (paddr == OFS_CMD);
   wire           sel_data  = (paddr == OFS_DATA);
   wire           sel_ist   = (paddr == OFS_IRQ_STAT);
   wire           sel_imsk  = (paddr == OFS_IRQ_MASK);
   wire           mapped    = sel_cmd || sel_data || sel_ist || sel_imsk;
   wire           setup_rd  = psel && !penable && !pwrite;
   wire           acc_wr    = psel && penable && pwrite && mapped;
   wire           wr_cmd    = acc_wr && sel_cmd;
   wire           wr_data   = acc_wr && sel_data;
   wire           wr_ist    = acc_wr && sel_ist;
   wire           wr_imsk   = acc_wr && sel_imsk;

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_ff;

   // ------------------------------------------------------------------
   // command start and frame set-up
   // ------------------------------------------------------------------
   // commands written while busy are dropped
   wire           sw_start  = wr_cmd && pwdata[CMD_BUSY_BIT] && !busy_ff;
   wire           boot_go   = boot_ff && !busy_ff;
   wire           start     = sw_start || boot_go;
   wire eprc_op_t start_op  = boot_go ? EPRC_OP_RELOAD : eprc_op_t'(pwdata[CMD_OP_LSB +: 3]);
   wire [7:0]     start_adr = boot_go ? 8'h00 : pwdata[7:0];

   function automatic logic [10:0] frame_hdr(input eprc_op_t op, input logic [7:0] adr);
      logic [1:0] w;
      logic [7:0] a;
      w = WIRE_EXT;
      a = adr;
      case (op)
         EPRC_OP_READ,
         EPRC_OP_RELOAD: w = WIRE_READ;
         EPRC_OP_WRITE:  w = WIRE_WRITE;
         EPRC_OP_ERASE:  w = WIRE_ERASE;
         EPRC_OP_DISWR:  a = EXT_DISWR;
         EPRC_OP_ENWR:   a = EXT_ENWR;
         EPRC_OP_WRALL:  a = EXT_WRALL;
         EPRC_OP_ERALL:  a = EXT_ERALL;
         default:        w = WIRE_EXT;
      endcase
      return {1'b1, w, a};
   endfunction

   // only these wait for the memory's ready answer and so can time out
   function automatic logic needs_poll(input eprc_op_t op);
      return (op == EPRC_OP_WRITE) || (op == EPRC_OP_WRALL) ||
             (op == EPRC_OP_ERASE) || (op == EPRC_OP_ERALL);
   endfunction

   function automatic logic has_data(input eprc_op_t op);
      return (op == EPRC_OP_WRITE) || (op == EPRC_OP_WRALL);
   endfunction

   function automatic logic reads_byte(input eprc_op_t op);
      return (op == EPRC_OP_READ) || (op == EPRC_OP_RELOAD);
   endfunction

   // ------------------------------------------------------------------
   // timing sources
   // ------------------------------------------------------------------
   logic          half_tick;
   logic          tmo_hit;

   eprc_tick #(.W(SCLK_W)) u_sclk_tick
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .run     ((st_ff == ST_SHIFT) || (st_ff == ST_GAP)),
      .limit   (SCLK_W'(SCLK_HALF)),
      .hit     (half_tick)
   );

   eprc_tick #(.W(TMO_W)) u_tmo_tick
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .run     (st_ff == ST_POLL),
      .limit   (TMO_W'(TMO_CYCLES)),
      .hit     (tmo_hit)
   );

   // ------------------------------------------------------------------
   // sequence events
   // ------------------------------------------------------------------
   wire           last_bit  = (bit_ff == nbits_ff - 5'h01);
   wire           shift_end = (st_ff == ST_SHIFT) && half_tick && sclk_ff && last_bit;
   // a line held high answers the poll two cycles into the poll state, so it never times out
   // the synchronised line lags chip select by two cycles, so early samples are stale
   wire           poll_ok   = (st_ff == ST_POLL) && poll_age_ff[1] && din_ff;
   wire           poll_to   = (st_ff == ST_POLL) && !din_ff && tmo_hit;
   wire           finish    = (shift_end && !needs_poll(op_ff)) || poll_ok || poll_to;
   wire [7:0]     rx_byte   = sh_in_ff;
   wire           rl_sig_ok = (rl_idx_ff != 3'h0) || (rx_byte == RELOAD_SIG);
   wire           rl_more   = finish && rl_ff && rl_sig_ok && (rl_idx_ff != RELOAD_LAST);
   wire           rl_good   = finish && rl_ff && (rl_idx_ff == RELOAD_LAST);
   wire           cmd_done  = finish && !rl_more;
   wire           rd_cap    = finish && !rl_ff && (op_ff == EPRC_OP_READ);
   wire [2:0]     rl_nidx   = rl_idx_ff + 3'h1;

   // ------------------------------------------------------------------
   // input synchroniser
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         din_meta_ff <= 1'b0;
         din_ff      <= 1'b0;
      end
      else
      begin
         din_meta_ff <= mem_dio_i;
         din_ff      <= din_meta_ff;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         poll_age_ff <= 2'h0;
      else if (st_ff != ST_POLL)
         poll_age_ff <= 2'h0;
      else if (poll_age_ff != 2'h3)
         poll_age_ff <= poll_age_ff + 2'h1;
   end

   // ------------------------------------------------------------------
   // serial sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff     <= ST_IDLE;
         sh_out_ff <= '0;
         sh_in_ff  <= 8'h00;
         bit_ff    <= 5'h00;
         nbits_ff  <= 5'h00;
         nsend_ff  <= 5'h00;
         sclk_ff   <= 1'b0;
         cs_ff     <= 1'b0;
         oe_ff     <= 1'b0;
      end
      else if (start || rl_go_ff)
      begin
         // reload walks the signature and six address bytes, chip select low a cycle between
         st_ff     <= ST_SHIFT;
         sh_out_ff <= start ? {frame_hdr(start_op, start_adr), data_ff}
                            : {frame_hdr(EPRC_OP_READ, {5'h00, rl_idx_ff}), data_ff};
         bit_ff    <= 5'h00;
         nbits_ff  <= 5'(HDR_BITS + ((start && !reads_byte(start_op) && !has_data(start_op)) ? 0 : BYTE_BITS));
         nsend_ff  <= 5'(HDR_BITS + ((start && has_data(start_op)) ? BYTE_BITS : 0));
         sclk_ff   <= 1'b0;
         cs_ff     <= 1'b1;
         oe_ff     <= 1'b1;
      end
      else
      begin
         case (st_ff)
            ST_SHIFT:
               if (half_tick && !sclk_ff)
               begin
                  sclk_ff  <= 1'b1;
                  sh_in_ff <= {sh_in_ff[6:0], din_ff};
               end
               else if (half_tick)
               begin
                  sclk_ff   <= 1'b0;
                  bit_ff    <= bit_ff + 5'h01;
                  sh_out_ff <= {sh_out_ff[17:0], 1'b0};
                  oe_ff     <= (bit_ff + 5'h01) < nsend_ff;
                  if (last_bit)
                  begin
                     cs_ff <= 1'b0;
                     oe_ff <= 1'b0;
                     st_ff <= needs_poll(op_ff) ? ST_GAP : ST_IDLE;
                  end
               end
            // chip select low for one half period before the ready poll
            ST_GAP:
               if (half_tick)
               begin
                  cs_ff <= 1'b1;
                  st_ff <= ST_POLL;
               end
            ST_POLL:
               if (poll_ok || poll_to)
               begin
                  cs_ff <= 1'b0;
                  st_ff <= ST_IDLE;
               end
            default:
               st_ff <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // command register state
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op_ff     <= EPRC_OP_READ;
         addr_ff   <= CMD_ADDR_RST;
         busy_ff   <= 1'b0;
         boot_ff   <= 1'b1;
         rl_ff     <= 1'b0;
         rl_idx_ff <= 3'h0;
         rl_go_ff  <= 1'b0;
      end
      else
      begin
         rl_go_ff <= rl_more;
         if (start)
         begin
            op_ff     <= start_op;
            busy_ff   <= 1'b1;
            boot_ff   <= 1'b0;
            rl_ff     <= (start_op == EPRC_OP_RELOAD);
            rl_idx_ff <= 3'h0;
         end
         else if (cmd_done)
         begin
            busy_ff <= 1'b0;
            rl_ff   <= 1'b0;
         end
         else if (rl_more)
            rl_idx_ff <= rl_nidx;
         if (wr_cmd && !busy_ff)
            addr_ff <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------------
   // flags, data byte and station address
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         tmo_ff <= 1'b0;
      else if (poll_to)
         tmo_ff <= 1'b1;
      else if (start)
         tmo_ff <= 1'b0;
   end

   // set wins over a same-cycle write-one clear
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         loaded_ff <= 1'b0;
      else if (rl_good)
         loaded_ff <= 1'b1;
      else if (wr_cmd && pwdata[CMD_LOADED_BIT])
         loaded_ff <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         data_ff <= DATA_RST;
      else if (rd_cap)
         data_ff <= rx_byte;
      else if (wr_data && !busy_ff)
         data_ff <= pwdata[7:0];
   end

   // address bytes stored first to last, byte 1 lands in the top octet
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         sta_ff <= '0;
      else if (finish && rl_ff && (rl_idx_ff != 3'h0))
         sta_ff <= {sta_ff[39:0], rx_byte};
   end

   assign station_addr = sta_ff;

   // ------------------------------------------------------------------
   // interrupt status and mask
   // ------------------------------------------------------------------
   wire [1:0]     irq_set = {poll_to, cmd_done};
   wire [1:0]     irq_clr = wr_ist ? pwdata[1:0] : 2'h0;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_st_ff   <= 2'h0;
         irq_mask_ff <= IRQ_MASK_RST;
      end
      else
      begin
         irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_set;
         if (wr_imsk)
            irq_mask_ff <= pwdata[1:0];
      end
   end

   assign irq = |(irq_st_ff & irq_mask_ff);

   // ------------------------------------------------------------------
   // read data, captured in the setup phase
   // ------------------------------------------------------------------
   wire [31:0]    cmd_word  = {busy_ff, op_ff, 18'h00000, tmo_ff, loaded_ff, addr_ff};
   wire [31:0]    rd_mux    = sel_cmd  ? cmd_word :
                              sel_data ? {24'h000000, data_ff} :
                              sel_ist  ? {30'h00000000, irq_st_ff} :
                              sel_imsk ? {30'h00000000, irq_mask_ff} : 32'h00000000;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         prdata_ff <= 32'h00000000;
      else if (setup_rd)
         prdata_ff <= rd_mux;
   end

   // ------------------------------------------------------------------
   // memory pins
   // ------------------------------------------------------------------
   assign mem_cs     = cs_ff;
   assign mem_clk    = sclk_ff;
   assign mem_dio_o  = sh_out_ff[18];
   assign mem_dio_oe = oe_ff;

endmodule

// ==== tb/eprc_ctrl_sva.sv ====
// concurrent checks on the serial memory controller's ports
`timescale 1ns/100ps
module eprc_ctrl_sva
   import eprc_pkg::*;
#(
   parameter int TMO_CYCLES = 200,
   parameter int SCLK_HALF  = 4
)
(
   input wire logic              clk_sys,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              irq,
   input wire logic              mem_cs,
   input wire logic              mem_clk,
   input wire logic              mem_dio_o,
   input wire logic              mem_dio_oe,
   input wire logic              mem_dio_i,
   input wire logic [47:0]       station_addr
);
   logic        acc;
   logic        mapped;
   logic        lo_poll;
   logic [31:0] lo_cnt_ff;
   logic [31:0] nxt_lo_cnt;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   assign acc        = psel && penable;
   assign mapped     = paddr inside {OFS_CMD, OFS_DATA, OFS_IRQ_STAT, OFS_IRQ_MASK};
   assign lo_poll    = mem_cs && !mem_clk && !mem_dio_oe;
   // a silent memory holds the line low: count how long the controller waits on it
   assign nxt_lo_cnt = (lo_poll && !mem_dio_i) ? lo_cnt_ff + 32'h1 : 32'h0;

   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
         lo_cnt_ff <= 32'h0;
      else
         lo_cnt_ff <= nxt_lo_cnt;

   tmo_bound_a:
      assert property (lo_cnt_ff <= TMO_CYCLES + 8) else $error("low line wait not abandoned");
   high_done_a:
      assert property ((lo_poll && mem_dio_i) [*8] |-> ##[0:4] !mem_cs) else $error("ready line ignored");
   data_resv_a:
      assert property (acc && !pwrite && paddr == OFS_DATA |-> prdata[31:8] == 24'h0) else $error("data upper bits set");
   cmd_start_a:
      assert property (acc && pwrite && paddr == OFS_CMD && pwdata[31] && !mem_cs |=> mem_cs)
         else $error("command did not start");
   map_err_a:
      assert property (acc |-> pslverr == !mapped) else $error("slave error wrong");
   no_wait_a:
      assert property (psel |-> pready) else $error("wait state seen");
   clk_idle_a:
      assert property (!mem_cs |-> !mem_clk) else $error("serial clock outside frame");
   dout_hold_a:
      assert property (mem_cs && $rose(mem_clk) |=> $stable(mem_dio_o)) else $error("data moved at rising clock");

   cover property (lo_cnt_ff == TMO_CYCLES);
   cover property (acc && pwrite && paddr == OFS_CMD && pwdata[31]);
   cover property (acc && !mapped);
endmodule

// ==== tb/eprc_mem_model.sv ====
// behavioural serial memory behind the controller's pins
`timescale 1ns/100ps
module eprc_mem_model
(
   input  wire logic clk_sys,
   input  wire logic mem_cs,
   input  wire logic mem_clk,
   input  wire logic line,
   input  wire logic present,
   input  wire logic [31:0] busy_cyc,
   output      logic drv_en,
   output      logic drv_val
);
   logic [7:0]  mem [256];
   logic [18:0] sr;
   logic [10:0] hdr;
   logic        we_en = 1'b0;
   logic        pend = 1'b0;
   logic        poll = 1'b0;
   int          cnt = 0;
   int          bc;

   initial
   begin
      drv_en = 1'b0;
      drv_val = 1'b0;
   end

   always @(posedge mem_clk)
      if (mem_cs && present)
      begin
         sr = {sr[17:0], line};
         cnt++;
         if (cnt == 11)
            hdr = sr[10:0];
      end

   // read data leaves after the falling clock, msb first
   always @(negedge mem_clk)
      if (mem_cs && present && hdr[10:8] == 3'h6 && cnt >= 11 && cnt < 19)
      begin
         drv_en = 1'b1;
         drv_val = mem[hdr[7:0]][18 - cnt];
      end

   // programming is ignored unless writes were enabled, as on a real part
   always @(negedge mem_cs)
   begin
      if (present && cnt >= 11)
      begin
         if (hdr[9:8] == 2'h0 && hdr[7] == hdr[6])
            we_en = hdr[7];
         pend = we_en && (hdr[8] || hdr[9:8] == 2'h0 && hdr[7] != hdr[6]);
         for (int i = 0; i < 256; i++)
            if (pend && (hdr[9:8] == 2'h0 || 8'(i) == hdr[7:0]))
               mem[i] = (hdr[9] || hdr[9:6] == 4'h2) ? 8'hFF : sr[7:0];
      end
      cnt = 0;
      poll = 1'b0;
      drv_en = 1'b0;
   end

   // busy shows as a low line until the programming time has run
   always @(posedge mem_cs)
      if (pend)
      begin
         {pend, poll, drv_en, drv_val} = 4'h6;
         bc = busy_cyc;
      end

   always @(posedge clk_sys)
      if (poll)
      begin
         bc = (bc > 0) ? bc - 1 : 0;
         drv_val <= (bc == 0);
      end
endmodule

// ==== tb/eprc_ctrl_tb.sv ====
// self-checking bench for the serial memory command controller
`timescale 1ns/100ps
module eprc_ctrl_tb;
   import eprc_pkg::*;

   logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, irq;
   logic        mem_cs, mem_clk, mem_dio_o, mem_dio_oe, mem_line, present, pull_hi, drv_en, drv_val;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed, r;
   logic [47:0] station_addr;
   logic [7:0]  a, d;
   int          busy_cyc, mismatches, num_checks, cyc;

   assign mem_line = mem_dio_oe ? mem_dio_o : drv_en ? drv_val : pull_hi;

   eprc_ctrl #(.TMO_CYCLES(200), .SCLK_HALF(4)) uut (.clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .irq, .mem_cs, .mem_clk, .mem_dio_o, .mem_dio_oe, .mem_dio_i(mem_line), .station_addr);
   eprc_mem_model mdl (.clk_sys, .mem_cs, .mem_clk, .line(mem_line), .present, .busy_cyc, .drv_en, .drv_val);

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0);
   endfunction

   task automatic complete_run();
      if (mismatches == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one transfer, request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic idle();
      r = 32'h8000_0000;
      while (r[31] !== 1'b0)
         apb(1'b0, OFS_CMD, 32'h0);
   endtask

   task automatic run(input logic [2:0] op, input logic [7:0] ad);
      apb(1'b1, OFS_CMD, {1'b1, op, 20'h0, ad});
      idle();
   endtask

   task automatic stn_chk();
      for (int i = 0; i < 6; i++)
         chk({24'h0, station_addr[47 - 8 * i -: 8]}, {24'h0, mdl.mem[i + 1]});
   endtask

   initial
   begin
      clk_sys = 1'b0;
      forever
         #4 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         mismatches++;
         complete_run();
      end
   end

   initial
   begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {present, pull_hi} = 2'h3;
      busy_cyc = 10;
      seed = 32'h9027;
      for (int i = 0; i < 256; i++)
      begin
         seed = lfsr(seed);
         mdl.mem[i] = seed[7:0];
      end
      mdl.mem[0] = RELOAD_SIG;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      apb(1'b0, OFS_DATA, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, OFS_CMD, 32'h0);
      chk(r & 32'h3FF, 32'h0);
      idle();
      chk(r & 32'h300, 32'h100);
      stn_chk();
      apb(1'b1, OFS_CMD, 32'h100);
      apb(1'b0, OFS_CMD, 32'h0);
      chk(r & 32'h100, 32'h0);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      run(3'h2, 8'h0);
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         a = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[7:0];
         d = seed[15:8];
         busy_cyc <= int'(seed[21:16]) + 1;
         apb(1'b1, OFS_DATA, {24'hFF_FFFF, d});
         run(3'h3, a);
         chk(r & 32'h200, 32'h0);
         chk({24'h0, mdl.mem[a]}, {24'h0, d});
         apb(1'b1, OFS_DATA, 32'h0);
         run(3'h0, a);
         apb(1'b0, OFS_DATA, 32'h0);
         chk(r, {24'h0, d});
      end
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'h3);
      chk({31'h0, irq}, 32'h0);
      // write-all, erase and erase-all, then a refused write after disabling
      apb(1'b1, OFS_DATA, 32'h5A);
      run(3'h4, 8'h0);
      chk({24'h0, mdl.mem[seed[7:0]]}, 32'h5A);
      run(3'h5, 8'h09);
      chk({24'h0, mdl.mem[9]}, 32'hFF);
      run(3'h6, 8'h0);
      chk({24'h0, mdl.mem[200]}, 32'hFF);
      run(3'h1, 8'h0);
      apb(1'b1, OFS_DATA, 32'h0);
      run(3'h3, 8'h0C);
      chk({24'h0, mdl.mem[12]}, 32'hFF);
      mdl.mem[0] = RELOAD_SIG;
      for (int i = 1; i < 7; i++)
         mdl.mem[i] = 8'(i * 37);
      apb(1'b1, OFS_CMD, 32'h100);
      run(3'h7, 8'h0);
      chk(r & 32'h300, 32'h100);
      stn_chk();
      // memory never finishes programming
      run(3'h2, 8'h0);
      busy_cyc <= 100000;
      run(3'h3, 8'h21);
      chk(r & 32'h200, 32'h200);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(r & 32'h3, 32'h3);
      apb(1'b1, OFS_IRQ_MASK, 32'h2);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'h2);
      chk({31'h0, irq}, 32'h0);
      present <= 1'b0;
      run(3'h3, 8'h21);
      chk(r & 32'h200, 32'h0);
      run(3'h0, 8'h21);
      apb(1'b0, OFS_DATA, 32'h0);
      chk(r, 32'hFF);
      pull_hi <= 1'b0;
      apb(1'b1, OFS_CMD, 32'h100);
      for (int op = 0; op < 8; op++)
      begin
         run(3'(op), 8'h10);
         chk(r & 32'h300, (op inside {3, 4, 5, 6}) ? 32'h200 : 32'h0);
      end
      apb(1'b0, 12'h0C0, 32'h0);
      chk(r, 32'h0);
      complete_run();
   end
endmodule

bind eprc_ctrl eprc_ctrl_sva #(.TMO_CYCLES(TMO_CYCLES), .SCLK_HALF(SCLK_HALF)) chk_i (.clk_sys, .rst_n, .paddr, .psel,
   .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq, .mem_cs, .mem_clk, .mem_dio_o, .mem_dio_oe,
   .mem_dio_i, .station_addr);
